// ==== verilog/dac_const_sample_current_regs.sv ====
// Overview of operation
// - Bit 7 of channel B current register enables its current; resets to one.
// - Six-bit fine current code for channel B in bits 5-0, resets to 1Fh.
// - While update block is set, held constant sample stays unchanged.
// - With block clear, register constant sample passes to selected channels.
// - Sixteen-bit constant sample, reset zero, fed to channels selecting it.
// - Constant sample update reaches both channels in the same cycle.
// - Sixteen-bit regulator enable register, reset zero, bit 12 reserved.
// - Five-bit FIFO delay counts DAC clocks from sync edge to first samples.
//
// The AXI4-Lite interface to the registers was decided locally.
`include "dac_regs_params.svh"
module dac_const_sample_current_regs
    import dac_regs_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [15:0]          datapath_a,
    input  wire logic [15:0]          datapath_b,
    input  wire logic                 sync_edge,
    output dac_samples_t              dac_samples,
    output chan_b_current_t           chan_b_current,
    output regulator_enables_t        regulator_enables,
    output logic                      datapath_enable,
    output logic                      transmit_enable_a,
    output logic                      transmit_enable_b,
    output logic                      oscillator_enable,
    output logic                      fifo_first_sample,
    output logic                      fifo_timer_busy
);
    logic [7:0]   chan_b_current_ctrl_reg, chan_b_current_ctrl_next;
    logic [7:0]   hold_reg, hold_next;
    logic [15:0]  word_reg, word_next;
    logic [15:0]  regen_reg, regen_next;
    logic [7:0]   fdly_reg, fdly_next;
    logic [7:0]   pctl_reg, pctl_next;
    logic [15:0]  live_reg, live_next;
    dac_samples_t smp_reg, smp_next;

    logic [11:0]  aw_reg, aw_next;
    logic         awf_reg, awf_next;
    logic [31:0]  wd_reg, wd_next;
    logic [3:0]   ws_reg, ws_next;
    logic         wf_reg, wf_next;
    logic         bv_reg, bv_next;
    logic [1:0]   br_reg, br_next;
    logic         rv_reg, rv_next;
    logic [31:0]  rd_reg, rd_next;
    logic [1:0]   rr_reg, rr_next;

    logic [9:0]   widx;
    logic [9:0]   ridx;
    logic         do_write;

    assign widx     = aw_reg[11:2];
    assign ridx     = s_axi_araddr[11:2];
    assign do_write = awf_reg && wf_reg && !bv_reg;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0]  = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction : merge16

    // Bus slave: address and data may arrive in either order
    always_comb begin
        aw_next = aw_reg;
        awf_next = awf_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        wf_next = wf_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next  = s_axi_awaddr;
            awf_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
            wf_next = 1'b1;
        end
        if (do_write) begin
            awf_next = 1'b0;
            wf_next  = 1'b0;
            bv_next  = 1'b1;
            unique case (widx)
                `IDX_CHAN_B_CURRENT, `IDX_CONST_HOLD, `IDX_CONST_WORD,
                `IDX_REG_ENABLES, `IDX_FIFO_DELAY, `IDX_PATH_CTRL: br_next = 2'h0;
                default:                                           br_next = 2'h2;
            endcase
        end else if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = 2'h0;
            rd_next = 32'h0000_0000;
            unique case (ridx)
                `IDX_CHAN_B_CURRENT: rd_next[7:0]  = chan_b_current_ctrl_reg;
                `IDX_CONST_HOLD:     rd_next[7:0]  = hold_reg;
                `IDX_CONST_WORD:     rd_next[15:0] = word_reg;
                `IDX_REG_ENABLES:    rd_next[15:0] = regen_reg;
                `IDX_FIFO_DELAY:     rd_next[7:0]  = fdly_reg;
                `IDX_PATH_CTRL:      rd_next[7:0]  = pctl_reg;
                default:             rr_next       = 2'h2;
            endcase
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
    end

    assign s_axi_awready = !awf_reg;
    assign s_axi_wready  = !wf_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;

    // Register writes; reserved bits are stored and drive nothing, except regulator bit 12, which reaches regulator_enables
    always_comb begin
        chan_b_current_ctrl_next = chan_b_current_ctrl_reg;
        hold_next  = hold_reg;
        word_next  = word_reg;
        regen_next = regen_reg;
        fdly_next  = fdly_reg;
        pctl_next  = pctl_reg;
        if (do_write && ws_reg[0]) begin
            unique case (widx)
                `IDX_CHAN_B_CURRENT: chan_b_current_ctrl_next = wd_reg[7:0];
                `IDX_CONST_HOLD:     hold_next  = wd_reg[7:0];
                `IDX_FIFO_DELAY:     fdly_next  = wd_reg[7:0];
                `IDX_PATH_CTRL:      pctl_next  = wd_reg[7:0];
                default:             ;
            endcase
        end
        if (do_write && widx == `IDX_CONST_WORD) begin
            word_next = merge16(word_reg, wd_reg, ws_reg);
        end
        if (do_write && widx == `IDX_REG_ENABLES) begin
            regen_next = merge16(regen_reg, wd_reg, ws_reg);
        end
    end

    // Held copy only follows the register while the block bit is clear
    always_comb begin
        live_next = hold_reg[`HOLD_BIT] ? live_reg : word_reg;
        // One register feeds both lanes so both see a change together
        smp_next.sample_a = pctl_reg[`PC_SRCA_BIT] == SRC_CONSTANT ? live_next : datapath_a;
        smp_next.sample_b = pctl_reg[`PC_SRCB_BIT] == SRC_CONSTANT ? live_next : datapath_b;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chan_b_current_ctrl_reg <= `RST_CHAN_B_CURRENT;
            hold_reg  <= `RST_CONST_HOLD;
            word_reg  <= `RST_CONST_WORD;
            regen_reg <= `RST_REG_ENABLES;
            fdly_reg  <= `RST_FIFO_DELAY;
            pctl_reg  <= `RST_PATH_CTRL;
            live_reg  <= `RST_CONST_WORD;
            smp_reg   <= '0;
            aw_reg    <= 12'h000;
            awf_reg   <= 1'b0;
            wd_reg    <= 32'h0000_0000;
            ws_reg    <= 4'h0;
            wf_reg    <= 1'b0;
            bv_reg    <= 1'b0;
            br_reg    <= 2'h0;
            rv_reg    <= 1'b0;
            rd_reg    <= 32'h0000_0000;
            rr_reg    <= 2'h0;
        end else begin
            chan_b_current_ctrl_reg <= chan_b_current_ctrl_next;
            hold_reg  <= hold_next;
            word_reg  <= word_next;
            regen_reg <= regen_next;
            fdly_reg  <= fdly_next;
            pctl_reg  <= pctl_next;
            live_reg  <= live_next;
            smp_reg   <= smp_next;
            aw_reg    <= aw_next;
            awf_reg   <= awf_next;
            wd_reg    <= wd_next;
            ws_reg    <= ws_next;
            wf_reg    <= wf_next;
            bv_reg    <= bv_next;
            br_reg    <= br_next;
            rv_reg    <= rv_next;
            rd_reg    <= rd_next;
            rr_reg    <= rr_next;
        end
    end

    assign dac_samples                        = smp_reg;
    assign chan_b_current.chan_b_current_on   = chan_b_current_ctrl_reg[`CUR_ON_BIT];
    assign chan_b_current.chan_b_fine_current = chan_b_current_ctrl_reg[`FINE_MSB:0];
    assign regulator_enables                  = regulator_enables_t'(regen_reg);
    assign datapath_enable                    = pctl_reg[`PC_PATH_ON_BIT];
    assign transmit_enable_a                  = pctl_reg[`PC_TXA_BIT];
    assign transmit_enable_b                  = pctl_reg[`PC_TXB_BIT];
    assign oscillator_enable                  = pctl_reg[`PC_OSC_BIT];

    // Delay register is read only when sync_edge loads the count; changing it mid-count leaves the running count unchanged
    fifo_start_timer fifo_start_timer_inst (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .sync_edge    (sync_edge),
        .delay_count  (fdly_reg[`FIFO_DELAY_MSB:0]),
        .first_sample (fifo_first_sample),
        .busy         (fifo_timer_busy)
    );

    a_hold_freezes: assert property (@(posedge ref_clk) disable iff (srst)
        hold_reg[`HOLD_BIT] && $past(hold_reg[`HOLD_BIT]) |-> $stable(live_reg))
        else $error("constant sample changed while blocked");
    a_pass_through: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(hold_reg[`HOLD_BIT]) |-> live_reg == $past(word_reg))
        else $error("constant sample not passed through");
    a_both_lanes: assert property (@(posedge ref_clk) disable iff (srst)
        pctl_reg[`PC_SRCA_BIT] && pctl_reg[`PC_SRCB_BIT] && $stable(pctl_reg) |=> smp_reg.sample_a == smp_reg.sample_b)
        else $error("lanes disagree on constant sample");
    a_const_feed: assert property (@(posedge ref_clk) disable iff (srst)
        pctl_reg[`PC_SRCA_BIT] |=> smp_reg.sample_a == $past(live_next))
        else $error("constant source not fed to channel a");
    // Written value must reach the pins, not merely match the register
    a_cur_write_out: assert property (@(posedge ref_clk) disable iff (srst)
        do_write && ws_reg[0] && widx == `IDX_CHAN_B_CURRENT
        |=> chan_b_current.chan_b_current_on == $past(wd_reg[`CUR_ON_BIT])
            && chan_b_current.chan_b_fine_current == $past(wd_reg[`FINE_MSB:0]))
        else $error("current outputs do not follow write");
    a_cur_reset: assert property (@(posedge ref_clk) srst |=> chan_b_current_ctrl_reg == `RST_CHAN_B_CURRENT)
        else $error("current register reset wrong");
    a_regen_reset: assert property (@(posedge ref_clk)
        srst |=> regen_reg == `RST_REG_ENABLES && word_reg == `RST_CONST_WORD)
        else $error("regulator or sample reset wrong");
    a_fifo_timing: assert property (@(posedge ref_clk) disable iff (srst)
        sync_edge && fdly_reg[`FIFO_DELAY_MSB:0] == 5'h05 && !fifo_timer_busy ##1 !sync_edge [*5]
        |=> fifo_first_sample)
        else $error("first sample strobe late or early");
    a_bresp_once: assert property (@(posedge ref_clk) disable iff (srst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    c_hold_set: cover property (@(posedge ref_clk) disable iff (srst) hold_reg[0] && do_write && widx == `IDX_CONST_WORD);
    c_both_const: cover property (@(posedge ref_clk) disable iff (srst) pctl_reg[5:4] == 2'h3 && $changed(live_reg));
    c_fifo_fire: cover property (@(posedge ref_clk) disable iff (srst) fifo_first_sample);
endmodule : dac_const_sample_current_regs

// ==== verilog/dac_regs_params.svh ====
// Offsets, field positions, reset values and timing counts of the DAC register bank
`ifndef DAC_REGS_PARAMS_SVH
`define DAC_REGS_PARAMS_SVH

// Printed offsets are register indices; byte address is four times the index
`define IDX_CHAN_B_CURRENT     10'h172
`define IDX_CONST_HOLD         10'h180
`define IDX_CONST_WORD         10'h181
`define IDX_REG_ENABLES        10'h1A0
`define IDX_FIFO_DELAY         10'h200
// Own control register: datapath, transmit, oscillator enables and source selects
`define IDX_PATH_CTRL          10'h300

`define RST_CHAN_B_CURRENT     8'h9F
`define RST_CONST_HOLD         8'h00
`define RST_CONST_WORD         16'h0000
`define RST_REG_ENABLES        16'h0000
`define RST_FIFO_DELAY         8'h00
`define RST_PATH_CTRL          8'h00

`define CUR_ON_BIT             7
`define FINE_MSB               5
`define HOLD_BIT               0
`define FIFO_DELAY_MSB         4
`define PC_PATH_ON_BIT         0
`define PC_TXA_BIT             1
`define PC_TXB_BIT             2
`define PC_OSC_BIT             3
`define PC_SRCA_BIT            4
`define PC_SRCB_BIT            5

`define FIFO_START_CYCLES      5'h01

`endif

// ==== verilog/dac_regs_pkg.sv ====
// Types shared by the DAC register bank
package dac_regs_pkg;
    typedef enum logic [0:0] {
        SRC_DATAPATH = 1'b0,
        SRC_CONSTANT = 1'b1
    } sample_src_t;

    typedef struct packed {
        logic        clock_distribution_regulator_on;
        logic        clock_generation_regulator_on;
        logic        ref_receiver_regulator_on;
        logic        reserved_12;
        logic [1:0]  chan_b_mux_regulator_on;
        logic [1:0]  chan_b_switch_driver_regulator_on;
        logic [1:0]  chan_b_clock_driver_regulator_on;
        logic [1:0]  chan_a_mux_regulator_on;
        logic [1:0]  chan_a_switch_driver_regulator_on;
        logic [1:0]  chan_a_clock_driver_regulator_on;
    } regulator_enables_t;

    typedef struct packed {
        logic        chan_b_current_on;
        logic [5:0]  chan_b_fine_current;
    } chan_b_current_t;

    typedef struct packed {
        logic [15:0] sample_a;
        logic [15:0] sample_b;
    } dac_samples_t;
endpackage : dac_regs_pkg

// ==== verilog/fifo_start_timer.sv ====
// Counts DAC clocks from reference-sync edge to first-sample strobe
`include "dac_regs_params.svh"
module fifo_start_timer
    import dac_regs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       sync_edge,
    input  wire logic [4:0] delay_count,
    output logic            first_sample,
    output logic            busy
);
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic       busy_reg;
    logic       busy_next;
    logic       fire_reg;
    logic       fire_next;

    always_comb begin
        count_next = count_reg;
        busy_next  = busy_reg;
        fire_next  = 1'b0;
        if (sync_edge) begin
            // Zero delay fires right after the edge
            if (delay_count == 5'h00) begin
                fire_next = 1'b1;
                busy_next = 1'b0;
            end else begin
                count_next = delay_count - `FIFO_START_CYCLES;
                busy_next  = 1'b1;
            end
        end else if (busy_reg) begin
            if (count_reg == 5'h00) begin
                fire_next = 1'b1;
                busy_next = 1'b0;
            end else begin
                count_next = count_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_reg <= 5'h00;
            busy_reg  <= 1'b0;
            fire_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg  <= busy_next;
            fire_reg  <= fire_next;
        end
    end

    assign first_sample = fire_reg;
    assign busy         = busy_reg;
endmodule : fifo_start_timer

// ==== testbench/test_dac_const_sample_current_regs.sv ====
// Self-checking bench for the DAC register bank, driven over AXI4-Lite
`include "dac_regs_params.svh"
module test_dac_const_sample_current_regs
    import dac_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               ref_clk = 1'b0;
    logic               srst = 1'b1;
    logic [11:0]        s_axi_awaddr = 12'h000;
    logic               s_axi_awvalid = 1'b0;
    logic               s_axi_awready;
    logic [31:0]        s_axi_wdata = 32'h0000_0000;
    logic [3:0]         s_axi_wstrb = 4'h0;
    logic               s_axi_wvalid = 1'b0;
    logic               s_axi_wready;
    logic [1:0]         s_axi_bresp;
    logic               s_axi_bvalid;
    logic               s_axi_bready = 1'b0;
    logic [11:0]        s_axi_araddr = 12'h000;
    logic               s_axi_arvalid = 1'b0;
    logic               s_axi_arready;
    logic [31:0]        s_axi_rdata;
    logic [1:0]         s_axi_rresp;
    logic               s_axi_rvalid;
    logic               s_axi_rready = 1'b0;
    logic [15:0]        datapath_a = 16'h1234;
    logic [15:0]        datapath_b = 16'h5678;
    logic               sync_edge = 1'b0;
    dac_samples_t       dac_samples;
    chan_b_current_t    chan_b_current;
    regulator_enables_t regulator_enables;
    logic               datapath_enable;
    logic               transmit_enable_a;
    logic               transmit_enable_b;
    logic               oscillator_enable;
    logic               fifo_first_sample;
    logic               fifo_timer_busy;
    int                 mismatches = 0;
    int                 num_checks = 0;
    logic [7:0]         cur_pat [3] = '{8'h40, 8'h95, 8'hFF};
    logic [15:0]        reg_pat [4] = '{16'h0FFF, 16'hF000, 16'h1000, 16'hA5A5};
    logic [4:0]         dly_pat [3] = '{5'h00, 5'h05, 5'h1F};

    dac_const_sample_current_regs dac_const_sample_current_regs_inst (
        .ref_clk(ref_clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .datapath_a(datapath_a), .datapath_b(datapath_b), .sync_edge(sync_edge),
        .dac_samples(dac_samples), .chan_b_current(chan_b_current),
        .regulator_enables(regulator_enables), .datapath_enable(datapath_enable),
        .transmit_enable_a(transmit_enable_a), .transmit_enable_b(transmit_enable_b),
        .oscillator_enable(oscillator_enable), .fifo_first_sample(fifo_first_sample),
        .fifo_timer_busy(fifo_timer_busy)
    );

    always #25 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s response expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    task automatic timed_out(input string what);
        mismatches++;
        $display("Error %s expected handshake seen none", what);
        report_and_stop();
    endtask : timed_out

    // Address and data offered together; each dropped at the edge that takes it
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] strb,
                      input logic [1:0] exp_resp = 2'b00);
        logic ok;
        ok = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strb;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                ok = 1'b1;
                s_axi_bready <= 1'b0;
                chk_resp("write", exp_resp, s_axi_bresp);
            end
        end
        if (!ok) timed_out("write");
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string what,
                          input logic [1:0] exp_resp = 2'b00);
        logic ok;
        ok = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                ok = 1'b1;
                s_axi_rready <= 1'b0;
                chk_resp(what, exp_resp, s_axi_rresp);
                chk_val(what, exp, s_axi_rdata);
            end
        end
        if (!ok) timed_out(what);
    endtask : rd_chk

    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : settle

    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk(`IDX_CHAN_B_CURRENT, {24'h0, `RST_CHAN_B_CURRENT}, "current reset");
        rd_chk(`IDX_CONST_HOLD, {24'h0, `RST_CONST_HOLD}, "hold reset");
        rd_chk(`IDX_CONST_WORD, {16'h0, `RST_CONST_WORD}, "word reset");
        rd_chk(`IDX_REG_ENABLES, {16'h0, `RST_REG_ENABLES}, "regulator reset");
        rd_chk(`IDX_FIFO_DELAY, {24'h0, `RST_FIFO_DELAY}, "fifo delay reset");
        chk_val("current out reset", 32'h5F, {25'h0, chan_b_current});
        chk_val("samples reset", 32'h1234_5678, dac_samples);
        foreach (cur_pat[i]) begin
            wr(`IDX_CHAN_B_CURRENT, {24'h0, cur_pat[i]}, 4'h1);
            rd_chk(`IDX_CHAN_B_CURRENT, {24'h0, cur_pat[i]}, "current reg");
            chk_val("current out", {25'h0, cur_pat[i][7], cur_pat[i][5:0]}, {25'h0, chan_b_current});
        end
        foreach (reg_pat[i]) begin
            wr(`IDX_REG_ENABLES, {16'h0, reg_pat[i]}, 4'h3);
            rd_chk(`IDX_REG_ENABLES, {16'h0, reg_pat[i]}, "regulator reg");
            chk_val("regulator out", {16'h0, reg_pat[i]}, {16'h0, regulator_enables});
        end
        wr(`IDX_PATH_CTRL, 32'hCF, 4'h1);
        rd_chk(`IDX_PATH_CTRL, 32'hCF, "control reg");
        chk_val("enables", 32'hF, {28'h0, oscillator_enable, transmit_enable_b, transmit_enable_a, datapath_enable});
        wr(10'h001, 32'hFFFF_FFFF, 4'hF, 2'b10);
        rd_chk(10'h001, 32'h0, "unmapped", 2'b10);
        // Value loaded while the datapath is off, then both channels switched over
        wr(`IDX_PATH_CTRL, 32'h00, 4'h1);
        wr(`IDX_CONST_WORD, 32'hA5C3, 4'h3);
        wr(`IDX_PATH_CTRL, 32'h31, 4'h1);
        settle(3);
        chk_val("both constant", 32'hA5C3_A5C3, dac_samples);
        wr(`IDX_CONST_HOLD, 32'h01, 4'h1);
        wr(`IDX_CONST_WORD, 32'h1111, 4'h3);
        settle(4);
        chk_val("held sample", 32'hA5C3_A5C3, dac_samples);
        rd_chk(`IDX_CONST_WORD, 32'h1111, "word stored");
        // Reserved hold bits set while the block bit clears: release must still happen
        wr(`IDX_CONST_HOLD, 32'hFE, 4'h1);
        for (int k = 0; k < 4; k++) begin
            settle(1);
            chk_val("channels agree", {16'h0, dac_samples.sample_a}, {16'h0, dac_samples.sample_b});
        end
        chk_val("released sample", 32'h1111_1111, dac_samples);
        wr(`IDX_PATH_CTRL, 32'h11, 4'h1);
        settle(3);
        chk_val("a constant only", 32'h1111_5678, dac_samples);
        wr(`IDX_PATH_CTRL, 32'h21, 4'h1);
        settle(3);
        chk_val("b constant only", 32'h1234_1111, dac_samples);
        wr(`IDX_PATH_CTRL, 32'h00, 4'h1);
        foreach (dly_pat[i]) begin
            int n;
            wr(`IDX_FIFO_DELAY, {24'h0, 3'b111, dly_pat[i]}, 4'h1);
            rd_chk(`IDX_FIFO_DELAY, {24'h0, 3'b111, dly_pat[i]}, "fifo delay reg");
            @(posedge ref_clk);
            sync_edge <= 1'b1;
            @(posedge ref_clk);
            sync_edge <= 1'b0;
            n = 1;
            #1;
            chk_val("timer busy", {31'h0, dly_pat[i] != 5'h00}, {31'h0, fifo_timer_busy});
            while (fifo_first_sample !== 1'b1 && n < 40) begin
                settle(1);
                n++;
            end
            chk_val("first sample cycle", {27'h0, dly_pat[i]} + 32'd1, n);
        end
        report_and_stop();
    end
endmodule : test_dac_const_sample_current_regs
